// ==== src/prgb_defines.svh ====
`ifndef PRGB_DEFINES_SVH
`define PRGB_DEFINES_SVH

// Line geometry in pixel clocks
`define PRGB_H_ACTIVE    800
`define PRGB_H_TOTAL     928
`define PRGB_H_TOTAL_MIN 889
`define PRGB_H_TOTAL_MAX 1143
`define PRGB_H_SYNC      48
`define PRGB_H_BLANK     88
`define PRGB_H_FPORCH    40
// Frame geometry in lines
`define PRGB_V_ACTIVE    480
`define PRGB_V_TOTAL     525
`define PRGB_V_TOTAL_MIN 513
`define PRGB_V_TOTAL_MAX 767
`define PRGB_V_SYNC      3
`define PRGB_V_BLANK     32
`define PRGB_V_FPORCH    13
// Pixel clock and core clock figures in MHz
`define PRGB_PCLK_TYP_MHZ 30
`define PRGB_PCLK_MAX_MHZ 50
`define PRGB_CORE_MHZ     250

`endif

// ==== src/prgb_pkg.sv ====
package prgb_pkg;
    typedef logic [7:0]  prgb_comp_t;
    typedef logic [23:0] prgb_pixel_t;
    typedef logic [10:0] prgb_count_t;
    typedef enum logic [1:0] {
        PRGB_IDLE   = 2'b00,
        PRGB_ACTIVE = 2'b01,
        PRGB_DONE   = 2'b10
    } prgb_frame_state_t;
endpackage

// ==== src/prgb_link_if.sv ====
`timescale 1ns/1ps
interface prgb_link_if;
    logic                pixel_clock_pin;
    logic                line_sync_in;
    logic                frame_sync_in;
    logic                pixel_valid_in;
    prgb_pkg::prgb_comp_t red_bus;
    prgb_pkg::prgb_comp_t green_bus;
    prgb_pkg::prgb_comp_t blue_bus;

    modport host (
        output pixel_clock_pin,
        output line_sync_in,
        output frame_sync_in,
        output pixel_valid_in,
        output red_bus,
        output green_bus,
        output blue_bus
    );
    modport panel (
        input pixel_clock_pin,
        input line_sync_in,
        input frame_sync_in,
        input pixel_valid_in,
        input red_bus,
        input green_bus,
        input blue_bus
    );
endinterface

// ==== src/prgb_host.sv ====
`timescale 1ns/1ps
`include "prgb_defines.svh"
// Summary of operation
// R01: Valid low means sync-only; else valid plus sync
// R02: Valid strobe marks exactly the picture data clocks
// R03: Continuous pixel clock, one pixel per clock
// R04: Three 8-bit colour buses, 24 bits in all
// R05: One line sync pulse per line
// R06: One frame sync pulse per frame
// R07: Exactly 800 active pixels per line
// R08: Line total 889 to 1143 clocks, typical 928
// R09: Line sync 1 to 255 clocks, typical 48
// R10: Sync-only horizontal blanking is 88 clocks
// R11: Front porch 1 to 255 clocks, typical 40
// R12: Pixel clock at most 50 MHz, typical 30
// R13: Exactly 480 active lines per frame
// R14: Frame total 513 to 767 lines, typical 525
// R15: Frame sync 3 to 255 lines, typical 3
// R16: Sync-only vertical blanking is 32 lines
// R17: Vertical front porch 1 to 255 lines
// R18: Blanking counted from sync leading edge
// R19: Panel ignores colour outside valid pixels
module prgb_host #(
    parameter int CLK_DIV  = 5,
    parameter int H_SYNC   = `PRGB_H_SYNC,
    parameter int H_FPORCH = `PRGB_H_FPORCH,
    parameter int V_SYNC   = `PRGB_V_SYNC,
    parameter int V_FPORCH = `PRGB_V_FPORCH
) (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst,
    // User side
    input  wire logic            use_valid,
    input  wire prgb_pkg::prgb_pixel_t pixel_data,
    output logic                 pixel_req,
    output logic                 frame_start,
    // Link
    prgb_link_if.host            link
);
    import prgb_pkg::*;

    localparam int H_TOTAL = `PRGB_H_BLANK + `PRGB_H_ACTIVE + H_FPORCH;
    localparam int V_TOTAL = `PRGB_V_BLANK + `PRGB_V_ACTIVE + V_FPORCH;

    initial begin
        if (CLK_DIV < 5 || CLK_DIV > 255) $error("CLK_DIV out of range"); // R12
        if (H_SYNC < 1 || H_SYNC > 255 || H_SYNC >= `PRGB_H_BLANK) $error("H_SYNC out of range"); // R09
        if (H_FPORCH < 1 || H_FPORCH > 255) $error("H_FPORCH out of range"); // R11
        if (H_TOTAL < `PRGB_H_TOTAL_MIN || H_TOTAL > `PRGB_H_TOTAL_MAX) $error("Line total out of range"); // R08
        if (V_SYNC < 3 || V_SYNC > 255 || V_SYNC >= `PRGB_V_BLANK) $error("V_SYNC out of range"); // R15
        if (V_FPORCH < 1 || V_FPORCH > 255) $error("V_FPORCH out of range"); // R17
        if (V_TOTAL < `PRGB_V_TOTAL_MIN || V_TOTAL > `PRGB_V_TOTAL_MAX) $error("Frame total out of range"); // R14
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel clock divider and counters
    logic [7:0]  div_reg,  div_next;
    logic        pclk_reg, pclk_next;
    prgb_count_t h_reg,    h_next;
    prgb_count_t v_reg,    v_next;
    logic        hs_reg,   hs_next;
    logic        vs_reg,   vs_next;
    logic        de_reg,   de_next;
    prgb_pixel_t rgb_reg,  rgb_next;
    logic        req_reg,  req_next;
    logic        fs_reg,   fs_next;
    logic        fall;
    logic        act;

    always_comb begin
        div_next  = div_reg;
        pclk_next = pclk_reg;
        h_next    = h_reg;
        v_next    = v_reg;
        hs_next   = hs_reg;
        vs_next   = vs_reg;
        de_next   = de_reg;
        rgb_next  = rgb_reg;
        req_next  = 1'b0;
        fs_next   = 1'b0;
        fall      = 1'b0;
        act       = 1'b0;
        // Free running divider, data change on falling edge
        if (div_reg == 8'((CLK_DIV + 1) / 2 - 1) && pclk_reg) begin // R03
            div_next  = 8'h00;
            pclk_next = 1'b0;
            fall      = 1'b1;
        end else if (div_reg == 8'(CLK_DIV / 2 - 1) && !pclk_reg) begin
            div_next  = 8'h00;
            pclk_next = 1'b1;
        end else begin
            div_next = div_reg + 8'h01;
        end
        if (fall) begin
            if (h_reg == prgb_count_t'(H_TOTAL - 1)) begin // R08
                h_next = '0;
                if (v_reg == prgb_count_t'(V_TOTAL - 1)) begin // R14
                    v_next = '0;
                end else begin
                    v_next = v_reg + 11'h001;
                end
            end else begin
                h_next = h_reg + 11'h001;
            end
            hs_next = (h_next < prgb_count_t'(H_SYNC)); // R05 R09 R18
            vs_next = (v_next < prgb_count_t'(V_SYNC)); // R06 R15 R18
            act = (h_next >= prgb_count_t'(`PRGB_H_BLANK))                          // R10
                && (h_next < prgb_count_t'(`PRGB_H_BLANK + `PRGB_H_ACTIVE))         // R07
                && (v_next >= prgb_count_t'(`PRGB_V_BLANK))                         // R16
                && (v_next < prgb_count_t'(`PRGB_V_BLANK + `PRGB_V_ACTIVE));        // R13
            de_next  = use_valid & act; // R01 R02
            rgb_next = act ? pixel_data : 24'h000000; // R04
            req_next = act;
            fs_next  = (h_next == '0) && (v_next == '0);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_reg  <= 8'h00;
            pclk_reg <= 1'b0;
            h_reg    <= prgb_count_t'(H_TOTAL - 1);
            v_reg    <= prgb_count_t'(V_TOTAL - 1);
            hs_reg   <= 1'b0;
            vs_reg   <= 1'b0;
            de_reg   <= 1'b0;
            rgb_reg  <= 24'h000000;
            req_reg  <= 1'b0;
            fs_reg   <= 1'b0;
        end else begin
            div_reg  <= div_next;
            pclk_reg <= pclk_next;
            h_reg    <= h_next;
            v_reg    <= v_next;
            hs_reg   <= hs_next;
            vs_reg   <= vs_next;
            de_reg   <= de_next;
            rgb_reg  <= rgb_next;
            req_reg  <= req_next;
            fs_reg   <= fs_next;
        end
    end

    assign pixel_req            = req_reg;
    assign frame_start          = fs_reg;
    assign link.pixel_clock_pin = pclk_reg;
    assign link.line_sync_in    = hs_reg;
    assign link.frame_sync_in   = vs_reg;
    assign link.pixel_valid_in  = de_reg;
    assign link.red_bus         = rgb_reg[23:16];
    assign link.green_bus       = rgb_reg[15:8];
    assign link.blue_bus        = rgb_reg[7:0];
endmodule

// ==== src/prgb_panel.sv ====
`timescale 1ns/1ps
`include "prgb_defines.svh"
module prgb_panel (
    // Core clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Link
    prgb_link_if.panel                 link,
    // User side, core domain
    output prgb_pkg::prgb_pixel_t      pix_data,
    output prgb_pkg::prgb_count_t      pix_x,
    output prgb_pkg::prgb_count_t      pix_y,
    output logic                       pix_strobe,
    output logic                       valid_mode
);
    import prgb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel clock domain capture
    logic        hs_q, vs_q, de_q;
    logic        lrst_meta_reg, lrst_reg;
    prgb_pixel_t rgb_q;
    prgb_count_t hc_reg, hc_next, vc_reg, vc_next;
    logic        hs_d, vs_d;
    logic        take;
    prgb_pixel_t word_reg, word_next;
    prgb_count_t wx_reg, wx_next, wy_reg, wy_next;
    logic        tog_reg, tog_next;
    logic        mode_reg, mode_next;

    always_ff @(posedge link.pixel_clock_pin) begin // R03
        hs_q    <= link.line_sync_in;
        vs_q    <= link.frame_sync_in;
        de_q    <= link.pixel_valid_in;
        rgb_q   <= {link.red_bus, link.green_bus, link.blue_bus}; // R04
        hs_d    <= hs_q;
        vs_d    <= vs_q;
    end

    // Link side reset, released on pixel clock
    always_ff @(posedge link.pixel_clock_pin or posedge rst) begin
        if (rst) begin
            lrst_meta_reg <= 1'b1;
            lrst_reg      <= 1'b1;
        end else begin
            lrst_meta_reg <= 1'b0;
            lrst_reg      <= lrst_meta_reg;
        end
    end

    always_comb begin
        hc_next   = hc_reg + 11'h001;
        vc_next   = vc_reg;
        if (hs_q && !hs_d) begin // R05 R18
            hc_next = '0;
            vc_next = vc_reg + 11'h001;
        end
        if (vs_q && !vs_d) begin // R06 R18
            vc_next = '0;
        end
        mode_next = mode_reg | de_q; // R01
        if (mode_next) begin
            take = de_q; // R01 R02 R19
        end else begin
            take = (hc_next >= prgb_count_t'(`PRGB_H_BLANK))                         // R10
                && (hc_next < prgb_count_t'(`PRGB_H_BLANK + `PRGB_H_ACTIVE))         // R07
                && (vc_next >= prgb_count_t'(`PRGB_V_BLANK))                         // R16
                && (vc_next < prgb_count_t'(`PRGB_V_BLANK + `PRGB_V_ACTIVE));        // R13 R19
        end
        // Position of the word now in rgb_q
        word_next = take ? rgb_q : word_reg;
        wx_next   = take ? hc_next - prgb_count_t'(`PRGB_H_BLANK) : wx_reg;
        wy_next   = take ? vc_next - prgb_count_t'(`PRGB_V_BLANK) : wy_reg;
        tog_next  = tog_reg ^ take;
    end

    always_ff @(posedge link.pixel_clock_pin or posedge lrst_reg) begin
        if (lrst_reg) begin
            hc_reg   <= 11'h000;
            vc_reg   <= 11'h000;
            word_reg <= 24'h000000;
            wx_reg   <= 11'h000;
            wy_reg   <= 11'h000;
            tog_reg  <= 1'b0;
            mode_reg <= 1'b0;
        end else begin
            hc_reg   <= hc_next;
            vc_reg   <= vc_next;
            word_reg <= word_next;
            wx_reg   <= wx_next;
            wy_reg   <= wy_next;
            tog_reg  <= tog_next;
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Toggle crossing into core domain
    logic [2:0]  tsync_reg;
    logic [1:0]  msync_reg;
    prgb_pixel_t od_reg, od_next;
    prgb_count_t ox_reg, ox_next, oy_reg, oy_next;
    logic        os_reg, os_next;

    always_comb begin
        os_next = tsync_reg[2] ^ tsync_reg[1];
        od_next = os_next ? word_reg : od_reg;
        ox_next = os_next ? wx_reg : ox_reg;
        oy_next = os_next ? wy_reg : oy_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tsync_reg <= 3'h0;
            msync_reg <= 2'h0;
            od_reg    <= 24'h000000;
            ox_reg    <= 11'h000;
            oy_reg    <= 11'h000;
            os_reg    <= 1'b0;
        end else begin
            tsync_reg <= {tsync_reg[1:0], tog_reg};
            msync_reg <= {msync_reg[0], mode_reg};
            od_reg    <= od_next;
            ox_reg    <= ox_next;
            oy_reg    <= oy_next;
            os_reg    <= os_next;
        end
    end

    assign pix_data   = od_reg;
    assign pix_x      = ox_reg;
    assign pix_y      = oy_reg;
    assign pix_strobe = os_reg;
    assign valid_mode = msync_reg[1];
endmodule

// ==== testbench/prgb_link_props.sv ====
`timescale 1ns/1ps
`include "prgb_defines.svh"
module prgb_link_props #(
    parameter int H_SYNC   = 48,
    parameter int H_FPORCH = 40,
    parameter int V_SYNC   = 3
) (
    // Core domain
    input logic                 core_clk,
    input logic                 rst,
    // Link
    input logic                 pixel_clock_pin,
    input logic                 line_sync_in,
    input logic                 frame_sync_in,
    input logic                 pixel_valid_in,
    input prgb_pkg::prgb_comp_t red_bus,
    input prgb_pkg::prgb_comp_t green_bus,
    input prgb_pkg::prgb_comp_t blue_bus
);
    import prgb_pkg::*;
    logic        hs_d_reg, vs_d_reg, seen_reg, seen_next;
    prgb_count_t hc_reg, hc_next, vc_reg, vc_next;
    logic [11:0] pos;
    assign pos = {1'b0, hc_reg} + 12'h001;
    ////////////////////////////////////////////////////////////////
    // Position in line and frame
    always_comb begin
        hc_next = (line_sync_in && !hs_d_reg) ? 11'h000 : hc_reg + 11'h001;
        vc_next = vc_reg;
        if (line_sync_in && !hs_d_reg) begin
            vc_next = (frame_sync_in && !vs_d_reg) ? 11'h000 : vc_reg + 11'h001;
        end
        seen_next = seen_reg | (frame_sync_in & ~vs_d_reg);
    end
    always_ff @(posedge pixel_clock_pin or posedge rst) begin
        if (rst) begin
            {hs_d_reg, vs_d_reg, seen_reg, hc_reg, vc_reg} <= '0;
        end else begin
            {hs_d_reg, vs_d_reg, seen_reg} <= {line_sync_in, frame_sync_in, seen_next};
            {hc_reg, vc_reg} <= {hc_next, vc_next};
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_pclk_period: assert property (@(posedge core_clk) disable iff (rst)
        $rose(pixel_clock_pin) |=> pixel_clock_pin ##3 !pixel_clock_pin ##1 $rose(pixel_clock_pin))
        else $error("pixel clock period or duty wrong");
    chk_bus_steady: assert property (@(posedge core_clk) disable iff (rst)
        !$fell(pixel_clock_pin) |-> $stable({line_sync_in, frame_sync_in, pixel_valid_in, red_bus, green_bus, blue_bus}))
        else $error("link changed away from falling pixel clock");
    chk_line_total: assert property (@(posedge pixel_clock_pin) disable iff (rst)
        $rose(line_sync_in) && seen_reg |-> hc_reg == `PRGB_H_BLANK + `PRGB_H_ACTIVE + H_FPORCH - 1)
        else $error("line length wrong");
    chk_hsync_width: assert property (@(posedge pixel_clock_pin) disable iff (rst)
        $fell(line_sync_in) |-> hc_reg == H_SYNC - 1) else $error("line sync width wrong");
    chk_valid_window: assert property (@(posedge pixel_clock_pin) disable iff (rst)
        seen_reg |-> pixel_valid_in == (pos >= `PRGB_H_BLANK && pos < `PRGB_H_BLANK + `PRGB_H_ACTIVE
        && vc_reg >= `PRGB_V_BLANK && vc_reg < `PRGB_V_BLANK + `PRGB_V_ACTIVE)) else $error("valid strobe misplaced");
    chk_vsync_width: assert property (@(posedge pixel_clock_pin) disable iff (rst)
        $fell(frame_sync_in) |-> $rose(line_sync_in) && vc_reg == V_SYNC - 1) else $error("frame sync width wrong");
    chk_frame_on_line: assert property (@(posedge pixel_clock_pin) disable iff (rst)
        $rose(frame_sync_in) |-> $rose(line_sync_in) && !pixel_valid_in) else $error("frame sync off line start");
    chk_sync_in_blank: assert property (@(posedge pixel_clock_pin) disable iff (rst)
        pixel_valid_in |-> !line_sync_in && !frame_sync_in) else $error("sync during active pixels");
    cov_frame_sync: cover property (@(posedge pixel_clock_pin) $fell(frame_sync_in));
    cov_valid_start: cover property (@(posedge pixel_clock_pin) $rose(pixel_valid_in));
    cov_full_line: cover property (@(posedge pixel_clock_pin) $rose(line_sync_in) && seen_reg);
endmodule

// ==== testbench/tb_parallel_rgb_panel_input.sv ====
`timescale 1ns/1ps
`include "prgb_defines.svh"
module tb_parallel_rgb_panel_input;
    import prgb_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    int   wire_cnt = 0;
    int   mismatches = 0;
    int   check_count = 0;
    ////////////////////////////////////////////////////////////////
    function automatic prgb_pixel_t pat(input int k);
        return {k[7:0], k[15:8] ^ 8'h5A, k[7:0] ^ 8'hA5};
    endfunction
    task automatic cmp_count(input prgb_count_t got, input prgb_count_t exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: count %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cmp_pixel(input prgb_pixel_t got, input prgb_pixel_t exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: pixel %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always #2 core_clk = ~core_clk;
    // Pair 0 runs with the valid strobe, pair 1 with syncs alone
    for (genvar i = 0; i < 2; i++) begin : g_pair
        logic        use_valid = 1'b0;
        prgb_pixel_t pixel_data = 24'h005AA5;
        logic        pixel_req, frame_start, pix_strobe, valid_mode;
        prgb_pixel_t pix_data;
        prgb_count_t pix_x, pix_y;
        int          req_cnt = 0;
        int          got_cnt = 0;
        int          fs_cnt = 0;
        prgb_link_if u_link ();
        prgb_host #(.H_SYNC(8), .H_FPORCH(1), .V_FPORCH(1)) u_prgb_host (
            .core_clk(core_clk), .rst(rst), .use_valid(use_valid), .pixel_data(pixel_data),
            .pixel_req(pixel_req), .frame_start(frame_start), .link(u_link));
        prgb_panel u_prgb_panel (
            .core_clk(core_clk), .rst(rst), .link(u_link), .pix_data(pix_data), .pix_x(pix_x),
            .pix_y(pix_y), .pix_strobe(pix_strobe), .valid_mode(valid_mode));
        if (i == 0) begin : g_chk
            prgb_link_props #(.H_SYNC(8), .H_FPORCH(1)) u_prgb_link_props (
                .core_clk(core_clk), .rst(rst), .pixel_clock_pin(u_link.pixel_clock_pin),
                .line_sync_in(u_link.line_sync_in), .frame_sync_in(u_link.frame_sync_in),
                .pixel_valid_in(u_link.pixel_valid_in), .red_bus(u_link.red_bus),
                .green_bus(u_link.green_bus), .blue_bus(u_link.blue_bus));
        end
        // Feed pixels and score what the panel delivers
        always @(posedge core_clk) begin
            use_valid <= (i == 0);
            if (pixel_req === 1'b1) begin
                req_cnt <= req_cnt + 1;
                pixel_data <= pat(req_cnt + 1);
            end
            if (frame_start === 1'b1) begin
                fs_cnt <= fs_cnt + 1;
            end
            if (pix_strobe === 1'b1 && !rst) begin
                cmp_count(pix_x, prgb_count_t'(got_cnt % `PRGB_H_ACTIVE));
                cmp_count(pix_y, prgb_count_t'(got_cnt / `PRGB_H_ACTIVE));
                cmp_pixel(pix_data, pat(got_cnt));
                got_cnt <= got_cnt + 1;
            end
        end
        // Colour on the wire while valid is high
        always @(posedge u_link.pixel_clock_pin) begin
            if (i == 0 && u_link.pixel_valid_in === 1'b1) begin
                cmp_pixel({u_link.red_bus, u_link.green_bus, u_link.blue_bus}, pat(wire_cnt));
                wire_cnt <= wire_cnt + 1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        for (int c = 0; c < 180000 && g_pair[0].got_cnt < 1600; c++) begin
            @(posedge core_clk);
        end
        repeat (20) @(posedge core_clk);
        cmp_count(prgb_count_t'(g_pair[0].got_cnt), 11'h640);
        cmp_count(prgb_count_t'(g_pair[1].got_cnt), 11'h640);
        cmp_count(prgb_count_t'(wire_cnt), 11'h640);
        cmp_count({10'h000, g_pair[0].valid_mode}, 11'h001);
        cmp_count({10'h000, g_pair[1].valid_mode}, 11'h000);
        cmp_count(prgb_count_t'(g_pair[0].fs_cnt), 11'h001);
        close_out;
    end
    initial begin
        repeat (200000) @(posedge core_clk);
        mismatches++;
        close_out;
    end
endmodule
